// ===== eth_cfg_pkg.sv
`default_nettype none
package eth_cfg_pkg;
    // register byte offsets: base, then set, clear and invert aliases
    localparam logic [7:0] cfg1_base_off = 8'h00;
    localparam logic [7:0] cfg1_set_off = 8'h04;
    localparam logic [7:0] cfg1_clr_off = 8'h08;
    localparam logic [7:0] cfg1_inv_off = 8'h0C;
    localparam logic [7:0] mcfg_base_off = 8'h10;
    localparam logic [7:0] mcfg_set_off = 8'h14;
    localparam logic [7:0] mcfg_clr_off = 8'h18;
    localparam logic [7:0] mcfg_inv_off = 8'h1C;

    // mac_config_one field positions
    localparam int mac_core_hold_bit = 15;
    localparam int backoff_rng_reset_bit = 14;
    localparam int rx_ctrl_sublayer_reset_bit = 11;
    localparam int rx_function_reset_bit = 10;
    localparam int tx_ctrl_sublayer_reset_bit = 9;
    localparam int tx_function_reset_bit = 8;
    localparam int loopback_bit = 4;
    localparam int tx_flow_ctrl_allow_bit = 3;
    localparam int rx_flow_ctrl_honour_bit = 2;
    localparam int accept_every_frame_bit = 1;
    localparam int frame_receive_gate_bit = 0;
    localparam logic [15:0] cfg1_reset_val = 16'h800D;
    localparam logic [15:0] cfg1_impl_mask = 16'hCF1F;

    // mgmt_port_config field positions
    localparam int mgmt_unit_reset_bit = 15;
    localparam int mdc_divider_select_lsb = 2;
    localparam int preamble_suppress_bit = 1;
    localparam int phy_scan_increment_bit = 0;
    localparam logic [15:0] mcfg_reset_val = 16'h0020;
    localparam logic [15:0] mcfg_impl_mask = 16'h803F;

    // mdc half periods in ref_clk cycles, minus one (divisor / 2 - 1)
    localparam logic [4:0] half_div4 = 5'h01;
    localparam logic [4:0] half_div6 = 5'h02;
    localparam logic [4:0] half_div8 = 5'h03;
    localparam logic [4:0] half_div10 = 5'h04;
    localparam logic [4:0] half_div14 = 5'h06;
    localparam logic [4:0] half_div20 = 5'h09;
    localparam logic [4:0] half_div28 = 5'h0D;
    localparam logic [4:0] half_div40 = 5'h13;

    localparam logic [4:0] scan_first_addr = 5'h01;

    typedef enum logic [1:0] {op_write, op_set, op_clr, op_inv} wr_op_e;
endpackage
`default_nettype wire

// ===== eth_mac_cfg_and_mgmt_ctrl.sv
// Added by the designer: the APB slave port and the placing of the registers.
`default_nettype none
// Function
// R1 - mac core hold bit resets to one and holds all mac logic in reset
// R2 - simulation reset bit resets the transmit backoff random generator
// R3 - receive control sublayer reset bit resets that sublayer logic
// R4 - receive function reset bit resets receive function logic
// R5 - transmit control sublayer reset bit resets that sublayer logic
// R6 - transmit function reset bit resets transmit function logic
// R7 - loopback bit routes transmit interface back into receive interface
// R8 - transmit flow control bit allows or blocks sending pause frames
// R9 - receive flow control bit makes mac act on or ignore pause frames
// R10 - accept all bit passes control frames, otherwise they are dropped
// R11 - frames are received only while receive enable bit is one
// R12 - 16 and 32 bit accesses work on all aliases, 8 bit ignored
// R13 - management reset bit holds the management unit in reset
// R14 - mdc is system clock divided by the selected factor
// R15 - select codes give divisors 4,4,6,8,10,14,20,28,40; others undefined
// R16 - preamble suppress bit drops the 32 bit preamble from cycles
// R17 - scan increment reads phy 1 up to target address, else one phy
// R18 - sub-block resets last while bit is one and release on clear
module eth_mac_cfg_and_mgmt_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // management engine
    input wire logic [4:0] phy_target_address,
    input wire logic mgmt_cycle_done,
    // mac sub-block controls
    output logic mac_core_hold,
    output logic backoff_rng_reset,
    output logic rx_ctrl_sublayer_reset,
    output logic rx_function_reset,
    output logic tx_ctrl_sublayer_reset,
    output logic tx_function_reset,
    output logic loopback_en,
    output logic tx_flow_ctrl_allow,
    output logic rx_flow_ctrl_honour,
    output logic accept_every_frame,
    output logic frame_receive_gate,
    // management controls
    output logic mgmt_unit_reset,
    output logic preamble_suppress,
    output logic phy_scan_increment,
    output logic [4:0] mgmt_phy_addr,
    output logic mdc
);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode and register file

    logic [15:0] cfg1_q, cfg1_d;
    logic [15:0] mcfg_q, mcfg_d;
    logic pready_q, pready_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic setup_c, access_c, hit_cfg1_c, hit_mcfg_c, size_ok_c;
    logic [15:0] lane_mask_c, wdat_c;
    eth_cfg_pkg::wr_op_e op_c;

    // no wait state; read data and pready are registered in the setup cycle and come straight from flops
    always_comb begin
        setup_c = psel && !penable;
        access_c = psel && penable && pready_q;
        hit_cfg1_c = (paddr[7:4] == eth_cfg_pkg::cfg1_base_off[7:4]);
        hit_mcfg_c = (paddr[7:4] == eth_cfg_pkg::mcfg_base_off[7:4]);
        // byte access is dropped silently; no error so software sees no fault
        size_ok_c = (pstrb == 4'hF) || (pstrb == 4'h3) || (pstrb == 4'hC); // R12
        lane_mask_c = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        wdat_c = pwdata[15:0];
        op_c = eth_cfg_pkg::wr_op_e'(paddr[3:2]);
        pready_d = setup_c;
        pslverr_d = setup_c && !(hit_cfg1_c || hit_mcfg_c) && (paddr[1:0] == 2'h0) ?
            1'b1 : (setup_c && paddr[1:0] != 2'h0);
        prdata_d = prdata_q;
        if (setup_c) begin
            prdata_d = 32'h0000_0000;
            if (!pwrite && hit_cfg1_c) begin
                prdata_d = {16'h0000, cfg1_q};
            end else if (!pwrite && hit_mcfg_c) begin
                prdata_d = {16'h0000, mcfg_q};
            end
        end
        cfg1_d = cfg1_q;
        mcfg_d = mcfg_q;
        if (access_c && pwrite && size_ok_c && !pslverr_q) begin // R12
            if (hit_cfg1_c) begin
                cfg1_d = apply_op(cfg1_q, wdat_c, lane_mask_c, op_c,
                    eth_cfg_pkg::cfg1_impl_mask);
            end
            if (hit_mcfg_c) begin
                mcfg_d = apply_op(mcfg_q, wdat_c, lane_mask_c, op_c,
                    eth_cfg_pkg::mcfg_impl_mask);
            end
        end
    end

    function automatic logic [15:0] apply_op(input logic [15:0] cur, input logic [15:0] w,
        input logic [15:0] lm, input eth_cfg_pkg::wr_op_e op, input logic [15:0] impl);
        logic [15:0] res;
        res = cur;
        unique case (op)
            eth_cfg_pkg::op_write: res = w;
            eth_cfg_pkg::op_set: res = cur | w;
            eth_cfg_pkg::op_clr: res = cur & ~w;
            eth_cfg_pkg::op_inv: res = cur ^ w;
        endcase
        return ((cur & ~lm) | (res & lm)) & impl;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg1_q <= eth_cfg_pkg::cfg1_reset_val; // R1
            mcfg_q <= eth_cfg_pkg::mcfg_reset_val;
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            cfg1_q <= cfg1_d;
            mcfg_q <= mcfg_d;
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // control outputs, one flop after the register

    logic [10:0] ctl_q, ctl_d;
    logic hold_c;

    // soft hold overrides every sub-block reset so nothing runs half-reset
    always_comb begin
        hold_c = cfg1_q[eth_cfg_pkg::mac_core_hold_bit];
        ctl_d[0] = hold_c; // R1
        ctl_d[1] = hold_c || cfg1_q[eth_cfg_pkg::backoff_rng_reset_bit]; // R2
        ctl_d[2] = hold_c || cfg1_q[eth_cfg_pkg::rx_ctrl_sublayer_reset_bit]; // R3 R18
        ctl_d[3] = hold_c || cfg1_q[eth_cfg_pkg::rx_function_reset_bit]; // R4 R18
        ctl_d[4] = hold_c || cfg1_q[eth_cfg_pkg::tx_ctrl_sublayer_reset_bit]; // R5 R18
        ctl_d[5] = hold_c || cfg1_q[eth_cfg_pkg::tx_function_reset_bit]; // R6 R18
        ctl_d[6] = cfg1_q[eth_cfg_pkg::loopback_bit]; // R7
        ctl_d[7] = cfg1_q[eth_cfg_pkg::tx_flow_ctrl_allow_bit]; // R8
        ctl_d[8] = cfg1_q[eth_cfg_pkg::rx_flow_ctrl_honour_bit]; // R9
        ctl_d[9] = cfg1_q[eth_cfg_pkg::accept_every_frame_bit]; // R10
        ctl_d[10] = cfg1_q[eth_cfg_pkg::frame_receive_gate_bit]; // R11
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl_q <= 11'h5BF;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign mac_core_hold = ctl_q[0];
    assign backoff_rng_reset = ctl_q[1];
    assign rx_ctrl_sublayer_reset = ctl_q[2];
    assign rx_function_reset = ctl_q[3];
    assign tx_ctrl_sublayer_reset = ctl_q[4];
    assign tx_function_reset = ctl_q[5];
    assign loopback_en = ctl_q[6];
    assign tx_flow_ctrl_allow = ctl_q[7];
    assign rx_flow_ctrl_honour = ctl_q[8];
    assign accept_every_frame = ctl_q[9];
    assign frame_receive_gate = ctl_q[10];

    ////////////////////////////////////////////////////////////////////////////
    // management unit controls, mdc divider and phy scan

    logic mrst_q, mrst_d, preamble_suppress_q, preamble_suppress_d, scan_q, scan_d, mdc_q, mdc_d;
    logic [4:0] div_cnt_q, div_cnt_d, half_c;
    logic [4:0] addr_q, addr_d;
    logic [3:0] sel_c;

    always_comb begin
        sel_c = mcfg_q[eth_cfg_pkg::mdc_divider_select_lsb +: 4];
        // undefined codes fall back to the slowest rate, the safe side for a phy
        unique case (sel_c) // R15
            4'h0, 4'h1: half_c = eth_cfg_pkg::half_div4;
            4'h2: half_c = eth_cfg_pkg::half_div6;
            4'h3: half_c = eth_cfg_pkg::half_div8;
            4'h4: half_c = eth_cfg_pkg::half_div10;
            4'h5: half_c = eth_cfg_pkg::half_div14;
            4'h6: half_c = eth_cfg_pkg::half_div20;
            4'h7: half_c = eth_cfg_pkg::half_div28;
            default: half_c = eth_cfg_pkg::half_div40;
        endcase
        mrst_d = mcfg_q[eth_cfg_pkg::mgmt_unit_reset_bit]; // R13
        preamble_suppress_d = mcfg_q[eth_cfg_pkg::preamble_suppress_bit]; // R16
        scan_d = mcfg_q[eth_cfg_pkg::phy_scan_increment_bit]; // R17
        div_cnt_d = div_cnt_q + 5'h01;
        mdc_d = mdc_q;
        // a new divisor takes hold at the next count compare, never mid glitch
        if (div_cnt_q >= half_c) begin // R14
            div_cnt_d = 5'h00;
            mdc_d = !mdc_q;
        end
        addr_d = addr_q;
        if (!scan_q) begin
            addr_d = phy_target_address; // R17
        end else if (mgmt_cycle_done) begin
            addr_d = (addr_q >= phy_target_address) ? eth_cfg_pkg::scan_first_addr :
                addr_q + 5'h01; // R17
        end
        if (mrst_q) begin // R13
            div_cnt_d = 5'h00;
            mdc_d = 1'b0;
            addr_d = scan_q ? eth_cfg_pkg::scan_first_addr : phy_target_address;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mrst_q <= 1'b0;
            preamble_suppress_q <= 1'b0;
            scan_q <= 1'b0;
            mdc_q <= 1'b0;
            div_cnt_q <= 5'h00;
            addr_q <= 5'h00;
        end else begin
            mrst_q <= mrst_d;
            preamble_suppress_q <= preamble_suppress_d;
            scan_q <= scan_d;
            mdc_q <= mdc_d;
            div_cnt_q <= div_cnt_d;
            addr_q <= addr_d;
        end
    end

    assign mgmt_unit_reset = mrst_q;
    assign preamble_suppress = preamble_suppress_q;
    assign phy_scan_increment = scan_q;
    assign mgmt_phy_addr = addr_q;
    assign mdc = mdc_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    hold_forces_resets_a: assert property (mac_core_hold |-> (backoff_rng_reset &&
        rx_ctrl_sublayer_reset && rx_function_reset && tx_ctrl_sublayer_reset &&
        tx_function_reset)) else $error("sub-block free while core held"); // R1
    rng_reset_follow_a: assert property ($rose(cfg1_q[14]) |=> backoff_rng_reset)
        else $error("rng reset not applied"); // R2
    rx_sub_follow_a: assert property (cfg1_q[11] |=> rx_ctrl_sublayer_reset)
        else $error("rx sublayer reset missing"); // R3
    rx_fun_follow_a: assert property (cfg1_q[10] |=> rx_function_reset)
        else $error("rx function reset missing"); // R4
    tx_sub_follow_a: assert property (cfg1_q[9] |=> tx_ctrl_sublayer_reset)
        else $error("tx sublayer reset missing"); // R5
    tx_fun_release_a: assert property ($fell(cfg1_q[8]) && !cfg1_q[15]
        |=> !tx_function_reset) else $error("tx function reset not released"); // R6 R18
    loop_follow_a: assert property (loopback_en == $past(cfg1_q[4]))
        else $error("loopback mismatch"); // R7
    pause_follow_a: assert property ({tx_flow_ctrl_allow, rx_flow_ctrl_honour} ==
        $past(cfg1_q[3:2])) else $error("pause controls mismatch"); // R8 R9
    pass_rx_follow_a: assert property ({accept_every_frame, frame_receive_gate} ==
        $past(cfg1_q[1:0])) else $error("receive controls mismatch"); // R10 R11
    byte_ignored_a: assert property (access_c && pwrite && !size_ok_c |=>
        $stable(cfg1_q) && $stable(mcfg_q)) else $error("byte write took effect"); // R12
    mgmt_hold_a: assert property (mrst_q |=> !mdc_q && div_cnt_q == 5'h00)
        else $error("mdc runs in mgmt reset"); // R13
    mdc_div4_a: assert property (!mrst_q && sel_c == 4'h0 && $rose(mdc_q) ##1
        (!mrst_q && sel_c == 4'h0) |-> mdc_q ##1 !mdc_q)
        else $error("divide by four wrong"); // R14 R15
    preamble_suppress_follow_a: assert property (preamble_suppress == $past(mcfg_q[1]))
        else $error("preamble control mismatch"); // R16
    scan_wrap_a: assert property (scan_q && !mrst_q && mgmt_cycle_done &&
        addr_q >= phy_target_address |=> addr_q == 5'h01)
        else $error("scan did not wrap to one"); // R17

    write_cfg1_c: cover property (access_c && pwrite && hit_cfg1_c && size_ok_c);
    half_write_c: cover property (access_c && pwrite && pstrb == 4'h3);
    release_core_c: cover property ($fell(mac_core_hold));
    scan_wrap_c: cover property (scan_q && mgmt_cycle_done && addr_q >= phy_target_address);

endmodule
`default_nettype wire

// ===== phy_mgmt_model.sv
`default_nettype none
module phy_mgmt_model (
    // clock
    input wire logic ref_clk,
    // management lines from the block
    input wire logic mdc,
    input wire logic mgmt_unit_reset,
    input wire logic preamble_suppress,
    // frame completion back to the block
    output var logic mgmt_cycle_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mdc_q;
    logic [6:0] bit_q;
    initial begin
        mdc_q = 1'b0;
        bit_q = 7'h00;
        mgmt_cycle_done = 1'b0;
    end
    // mdc is sampled, not used as a clock, as the far side sees it through pins
    always @(posedge ref_clk) begin
        mdc_q <= mdc;
        mgmt_cycle_done <= 1'b0;
        if (mgmt_unit_reset) begin
            bit_q <= 7'h00;
        end else if (mdc && !mdc_q) begin
            // 32 frame bits, plus 32 preamble bits unless suppressed
            if (bit_q == (preamble_suppress ? 7'h1F : 7'h3F)) begin
                bit_q <= 7'h00;
                mgmt_cycle_done <= 1'b1;
            end else begin
                bit_q <= bit_q + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] cb = eth_cfg_pkg::cfg1_base_off;
    localparam logic [7:0] mb = eth_cfg_pkg::mcfg_base_off;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [4:0] phy_target_address, mgmt_phy_addr;
    logic mgmt_cycle_done, mac_core_hold, backoff_rng_reset, rx_ctrl_sublayer_reset;
    logic rx_function_reset, tx_ctrl_sublayer_reset, tx_function_reset, loopback_en;
    logic tx_flow_ctrl_allow, rx_flow_ctrl_honour, accept_every_frame, frame_receive_gate;
    logic mgmt_unit_reset, preamble_suppress, phy_scan_increment, mdc;
    logic [15:0] out_vec;
    int err_total = 0;
    int n_tests = 0;
    int bits[5] = '{14, 11, 10, 9, 8};
    int divs[9] = '{4, 4, 6, 8, 10, 14, 20, 28, 40};
    int c;
    assign out_vec = {mac_core_hold, backoff_rng_reset, 2'b00, rx_ctrl_sublayer_reset,
        rx_function_reset, tx_ctrl_sublayer_reset, tx_function_reset, 3'b000, loopback_en,
        tx_flow_ctrl_allow, rx_flow_ctrl_honour, accept_every_frame, frame_receive_gate};
    eth_mac_cfg_and_mgmt_ctrl u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phy_target_address(phy_target_address), .mgmt_cycle_done(mgmt_cycle_done),
        .mac_core_hold(mac_core_hold), .backoff_rng_reset(backoff_rng_reset),
        .rx_ctrl_sublayer_reset(rx_ctrl_sublayer_reset), .rx_function_reset(rx_function_reset),
        .tx_ctrl_sublayer_reset(tx_ctrl_sublayer_reset), .tx_function_reset(tx_function_reset),
        .loopback_en(loopback_en), .tx_flow_ctrl_allow(tx_flow_ctrl_allow),
        .rx_flow_ctrl_honour(rx_flow_ctrl_honour), .accept_every_frame(accept_every_frame),
        .frame_receive_gate(frame_receive_gate), .mgmt_unit_reset(mgmt_unit_reset),
        .preamble_suppress(preamble_suppress), .phy_scan_increment(phy_scan_increment),
        .mgmt_phy_addr(mgmt_phy_addr), .mdc(mdc));
    phy_mgmt_model u_phy (.ref_clk(ref_clk), .mdc(mdc), .mgmt_unit_reset(mgmt_unit_reset),
        .preamble_suppress(preamble_suppress), .mgmt_cycle_done(mgmt_cycle_done));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stuck;
        err_total++;
        tally_and_finish();
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (n > 20) stuck();
        end while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] x;
        apb(1'b1, a, d, s, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        apb(1'b0, a, 32'h0000_0000, 4'hF, x);
        check(x, e);
    endtask
    // register readback, then the control outputs; sub-block resets follow the core hold
    task automatic cfg_is(input logic [15:0] e);
        rd_chk(cb, {16'h0000, e});
        check({16'h0000, out_vec}, {16'h0000, e | (e[15] ? 16'h4F00 : 16'h0000)});
    endtask
    task automatic wait_rise(output int n);
        logic p, hit;
        n = 0;
        p = mdc;
        do begin
            @(posedge ref_clk);
            n++;
            if (n > 200) stuck();
            hit = (p === 1'b0 && mdc === 1'b1);
            p = mdc;
        end while (!hit);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (n > 800) stuck();
        end while (mgmt_cycle_done !== 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, last_err} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        phy_target_address = 5'h03;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        cfg_is(16'h800D);
        rd_chk(mb, 32'h0000_0020);
        wr(cb, 32'h0000_001F, 4'hF);
        cfg_is(16'h001F);
        wr(cb, 32'h0000_0000, 4'hF);
        cfg_is(16'h0000);
        foreach (bits[i]) begin
            wr(eth_cfg_pkg::cfg1_set_off, 32'h1 << bits[i], 4'hF);
            cfg_is(16'h1 << bits[i]);
            wr(eth_cfg_pkg::cfg1_clr_off, 32'h1 << bits[i], 4'h3);
            cfg_is(16'h0000);
        end
        wr(eth_cfg_pkg::cfg1_inv_off, 32'h0000_0013, 4'hF);
        cfg_is(16'h0013);
        wr(cb, 32'h0000_FFFF, 4'h1);
        cfg_is(16'h0013);
        wr(cb, 32'h0000_800D, 4'h3);
        cfg_is(16'h800D);
        rd_chk(8'h02, 32'h0000_800D);
        check({31'h0, last_err}, 32'h1);
        foreach (divs[i]) begin
            wr(mb, 32'(i) << 2, 4'hF);
            wait_rise(c);
            wait_rise(c);
            wait_rise(c);
            check(32'(c), 32'(divs[i]));
        end
        wr(mb, 32'h0000_8000, 4'hF);
        // mdc is forced low one edge after the reset level is registered
        @(posedge ref_clk);
        repeat (30) begin
            @(posedge ref_clk);
            check({30'h0, mgmt_unit_reset, mdc}, 32'h2);
        end
        // scan across phys 1..3 with the divider at /4 to keep frames short
        wr(mb, 32'h0000_8001, 4'hF);
        wr(eth_cfg_pkg::mcfg_clr_off, 32'h0000_8000, 4'hF);
        for (int k = 0; k < 5; k++) begin
            wait_done();
            check({27'h0, mgmt_phy_addr}, 32'(k % 3 + 1));
        end
        wr(mb, 32'h0000_0002, 4'hF);
        phy_target_address <= 5'h06;
        repeat (3) @(posedge ref_clk);
        check({27'h0, mgmt_phy_addr, preamble_suppress}, 32'h0D);
        tally_and_finish();
    end
endmodule
`default_nettype wire
